// ---- pkg/avsom_pkg.sv ----
// types shared by the av offset meter
`include "avsom_regs.svh"
package avsom_pkg;
  // one-hot measurement states
  typedef enum logic [1:0] {
    AVSOM_IDLE = 2'b01,
    AVSOM_RUN  = 2'b10
  } avsom_state_type;

  // one received pixel, unsigned components
  typedef struct packed {
    logic [`AVSOM_CW-1:0] r;
    logic [`AVSOM_CW-1:0] g;
    logic [`AVSOM_CW-1:0] b;
  } avsom_pix_type;
endpackage

// ---- pkg/avsom_regs.svh ----
// register offsets, field positions, reset values for the av offset meter
`ifndef AVSOM_REGS_SVH
`define AVSOM_REGS_SVH
`define AVSOM_CW          12
`define AVSOM_OFF_CTRL    8'h00
`define AVSOM_OFF_COL_R   8'h04
`define AVSOM_OFF_COL_G   8'h08
`define AVSOM_OFF_COL_B   8'h0c
`define AVSOM_OFF_TOL     8'h10
`define AVSOM_OFF_ATHR    8'h14
`define AVSOM_OFF_MTIME   8'h18
`define AVSOM_OFF_ONTIME  8'h1c
`define AVSOM_OFF_STAT    8'h20
`define AVSOM_OFF_RES     8'h24
`define AVSOM_OFF_ISTAT   8'h28
`define AVSOM_OFF_ICLR    8'h2c
`define AVSOM_OFF_IEN     8'h30
`define AVSOM_CTRL_START  0
`define AVSOM_CTRL_DEP    1
`define AVSOM_DEP_12      2'h0
`define AVSOM_DEP_10      2'h1
`define AVSOM_DEP_8       2'h2
`define AVSOM_ST_BUSY     0
`define AVSOM_ST_DONE     1
`define AVSOM_ST_TMO      2
`define AVSOM_ST_CFG      3
`define AVSOM_ST_VHIT     4
`define AVSOM_ST_AHIT     5
`define AVSOM_IRQ_DONE    0
`define AVSOM_IRQ_TMO     1
`define AVSOM_IRQ_CFG     2
`define AVSOM_IRQ_W       3
`define AVSOM_RST_COL     12'h000
`define AVSOM_RST_TIME    32'h0000_0000
`define AVSOM_RST_WORD    32'h0000_0000
`endif

// ---- rtl/avsom_meter.sv ----
// av offset meter: video and audio triggers, offset timing, wishbone regs
//
// Summary of operation
// - Video trigger only when red, green and blue each lie within the inclusive bounds.
// - Bounds and received components are unsigned 12-bit values.
// - Untransmitted low bits of each component are zero before comparing.
// - With 8 bits per component the low 4 bits of every component are forced to zero.
// - Bounds made by adding or subtracting a tolerance saturate at 0 and 4095.
// - Audio trigger on the first sample whose magnitude exceeds the threshold.
// - The result is the time between video trigger and audio trigger.
// - Video first gives a negative result, audio first a positive one.
// - Inputs are observed only inside a window of programmed length.
// - A start is refused with a config error unless window exceeds on-time.
// - A missing trigger at window end aborts with timeout instead of result.
`include "avsom_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module avsom_meter #(
  parameter int AW = 16
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       irq_o,
  input  wire logic                  link_clk_i,
  input  wire logic                  pix_de_i,
  input  wire avsom_pkg::avsom_pix_type pix_i,
  input  wire logic                  aud_valid_i,
  input  wire logic [AW-1:0]         aud_i
);
  localparam int CW = `AVSOM_CW;
  localparam int IW = 3 + 3 * CW + AW;

  // audio width must fit one bus word beside zero padding
  if (AW < 8 || AW > 24) begin : g_chk
    $error("audio width out of range");
  end

  // ==========================================================
  // helper functions
  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        o[8*i +: 8] = n[8*i +: 8];
      end
    end
    return o;
  endfunction

  function automatic logic [CW-1:0] dmask(input logic [1:0] d);
    case (d)
      `AVSOM_DEP_10: dmask = 12'hffc;
      `AVSOM_DEP_8:  dmask = 12'hff0;
      default:       dmask = 12'hfff;
    endcase
  endfunction

  function automatic logic [CW-1:0] sat_add(input logic [CW-1:0] a,
                                            input logic [CW-1:0] t);
    logic [CW:0] s;
    s = {1'b0, a} + {1'b0, t};
    sat_add = s[CW] ? 12'hfff : s[CW-1:0];
  endfunction

  function automatic logic [CW-1:0] sat_sub(input logic [CW-1:0] a,
                                            input logic [CW-1:0] t);
    sat_sub = (a < t) ? 12'h000 : a - t;
  endfunction

  // ==========================================================
  // link input synchroniser and edge finder
  logic [IW-1:0] sy1_ff;
  logic [IW-1:0] sy2_ff;
  logic          lclk_d_ff;
  always_ff @(posedge clk_i) begin
    sy1_ff <= {link_clk_i, pix_de_i, pix_i, aud_valid_i, aud_i};
    sy2_ff <= sy1_ff;
    lclk_d_ff <= sy2_ff[IW-1];
  end

  // data is taken at each rising link edge seen on the synced clock
  wire                       lk_edge = sy2_ff[IW-1] & ~lclk_d_ff;
  wire                       s_de    = sy2_ff[IW-2];
  avsom_pkg::avsom_pix_type  s_pix;
  assign s_pix = sy2_ff[IW-3 -: 3*CW];
  wire                       s_aval  = sy2_ff[AW];
  wire [AW-1:0]              s_aud   = sy2_ff[AW-1:0];

  // ==========================================================
  // registers
  logic [1:0]    dep_ff;
  logic [CW-1:0] col_ff [3];
  logic [CW-1:0] tol_ff;
  logic [AW-1:0] athr_ff;
  logic [31:0]   mtime_ff;
  logic [31:0]   ontime_ff;
  logic [`AVSOM_IRQ_W-1:0] ien_ff;
  logic [`AVSOM_IRQ_W-1:0] ist_ff;
  logic [31:0]   dat_ff;
  logic          ack_ff;
  logic          irq_ff;

  // bus decode
  wire        req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        wr  = req & wb_we_i;
  wire        w_ctrl  = wr & (wb_adr_i == `AVSOM_OFF_CTRL);
  wire        w_col_r = wr & (wb_adr_i == `AVSOM_OFF_COL_R);
  wire        w_col_g = wr & (wb_adr_i == `AVSOM_OFF_COL_G);
  wire        w_col_b = wr & (wb_adr_i == `AVSOM_OFF_COL_B);
  wire        w_tol   = wr & (wb_adr_i == `AVSOM_OFF_TOL);
  wire        w_athr  = wr & (wb_adr_i == `AVSOM_OFF_ATHR);
  wire        w_mtime = wr & (wb_adr_i == `AVSOM_OFF_MTIME);
  wire        w_ontm  = wr & (wb_adr_i == `AVSOM_OFF_ONTIME);
  wire        w_iclr  = wr & (wb_adr_i == `AVSOM_OFF_ICLR);
  wire        w_ien   = wr & (wb_adr_i == `AVSOM_OFF_IEN);
  wire [31:0] c_new   = wmerge({29'h0, dep_ff, 1'b0}, wb_dat_i, wb_sel_i);
  wire        start   = w_ctrl & c_new[`AVSOM_CTRL_START];
  wire [2:0]  w_col   = {w_col_b, w_col_g, w_col_r};

  // ==========================================================
  // measurement core state
  avsom_pkg::avsom_state_type st_ff;
  logic [31:0]   ts_ff;
  logic [31:0]   win_ff;
  logic          vhit_ff;
  logic          ahit_ff;
  logic [31:0]   vts_ff;
  logic [31:0]   ats_ff;
  logic [31:0]   res_ff;
  logic          done_ff;
  logic          tmo_ff;
  logic          cfg_ff;

  // colour window per component: mask, bounds, inclusive compare
  wire [CW-1:0] rx_c [3];
  wire [CW-1:0] lo_c [3];
  wire [CW-1:0] hi_c [3];
  wire [2:0]    in_c;
  assign rx_c[0] = s_pix.r;
  assign rx_c[1] = s_pix.g;
  assign rx_c[2] = s_pix.b;
  for (genvar i = 0; i < 3; i++) begin : g_cmp
    wire [CW-1:0] m = rx_c[i] & dmask(dep_ff);
    assign lo_c[i] = sat_sub(col_ff[i], tol_ff);
    assign hi_c[i] = sat_add(col_ff[i], tol_ff);
    // unsigned 12-bit compare, both ends inclusive
    assign in_c[i] = (m >= lo_c[i]) && (m <= hi_c[i]);
  end

  // audio magnitude, so that either polarity of a burst triggers
  wire [AW-1:0] a_mag = s_aud[AW-1] ? (~s_aud + 1'b1) : s_aud;
  wire run   = (st_ff == avsom_pkg::AVSOM_RUN);
  wire v_now = run & lk_edge & s_de & (&in_c) & ~vhit_ff;
  wire a_now = run & lk_edge & s_aval & (a_mag > athr_ff) & ~ahit_ff;
  wire got_v = vhit_ff | v_now;
  wire got_a = ahit_ff | a_now;
  wire both  = got_v & got_a;
  wire w_end = run & (win_ff == mtime_ff - 32'h1);
  wire cfg_ok = mtime_ff > ontime_ff;
  wire [31:0] nxt_vts = v_now ? ts_ff : vts_ff;
  wire [31:0] nxt_ats = a_now ? ts_ff : ats_ff;
  wire ev_done = run & both;
  wire ev_tmo  = w_end & ~both;
  wire ev_cfg  = start & ~cfg_ok;

  // free-running timestamp source
  always_ff @(posedge clk_i) begin
    ts_ff <= rst_i ? 32'h0 : ts_ff + 32'h1;
  end

  // run control; a restart clears hit, done and timeout flags, timestamps and window count, but keeps the result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= avsom_pkg::AVSOM_IDLE;
      {vhit_ff, ahit_ff, done_ff, tmo_ff, cfg_ff} <= 5'h0;
      {vts_ff, ats_ff, res_ff, win_ff} <= {4{`AVSOM_RST_TIME}};
    end else if (start) begin
      st_ff <= cfg_ok ? avsom_pkg::AVSOM_RUN : avsom_pkg::AVSOM_IDLE;
      cfg_ff <= ~cfg_ok;
      {vhit_ff, ahit_ff, done_ff, tmo_ff} <= 4'h0;
      {vts_ff, ats_ff, win_ff} <= {3{`AVSOM_RST_TIME}};
    end else begin
      case (st_ff)
        avsom_pkg::AVSOM_RUN: begin
          vhit_ff <= got_v;
          ahit_ff <= got_a;
          vts_ff <= nxt_vts;
          ats_ff <= nxt_ats;
          win_ff <= win_ff + 32'h1;
          if (both) begin
            res_ff <= nxt_vts - nxt_ats;
            done_ff <= 1'b1;
            st_ff <= avsom_pkg::AVSOM_IDLE;
          end else if (w_end) begin
            tmo_ff <= 1'b1;
            st_ff <= avsom_pkg::AVSOM_IDLE;
          end
        end
        default: st_ff <= avsom_pkg::AVSOM_IDLE;
      endcase
    end
  end

  // ==========================================================
  // software registers; merged words are named so they can be sliced
  wire [31:0] tol_m  = wmerge({20'h0, tol_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] athr_m = wmerge({{(32-AW){1'b0}}, athr_ff}, wb_dat_i, wb_sel_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dep_ff <= `AVSOM_DEP_12;
      tol_ff <= `AVSOM_RST_COL;
      athr_ff <= AW'(`AVSOM_RST_WORD);
      mtime_ff <= `AVSOM_RST_TIME;
      ontime_ff <= `AVSOM_RST_TIME;
      ien_ff <= '0;
    end else begin
      if (w_ctrl) dep_ff <= c_new[`AVSOM_CTRL_DEP +: 2];
      if (w_tol) tol_ff <= tol_m[CW-1:0];
      if (w_athr) athr_ff <= athr_m[AW-1:0];
      if (w_mtime) mtime_ff <= wmerge(mtime_ff, wb_dat_i, wb_sel_i);
      if (w_ontm) ontime_ff <= wmerge(ontime_ff, wb_dat_i, wb_sel_i);
      if (w_ien) ien_ff <= wb_dat_i[`AVSOM_IRQ_W-1:0];
    end
  end

  // colour reference registers, one word per component
  for (genvar i = 0; i < 3; i++) begin : g_col
    wire [31:0] col_m = wmerge({20'h0, col_ff[i]}, wb_dat_i, wb_sel_i);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        col_ff[i] <= `AVSOM_RST_COL;
      end else if (w_col[i]) begin
        col_ff[i] <= col_m[CW-1:0];
      end
    end
  end

  // interrupt flags: a new event wins over a clear in the same cycle
  wire [`AVSOM_IRQ_W-1:0] i_set = {ev_cfg, ev_tmo, ev_done};
  wire [`AVSOM_IRQ_W-1:0] i_clr = w_iclr ? wb_dat_i[`AVSOM_IRQ_W-1:0] : '0;
  wire [`AVSOM_IRQ_W-1:0] nxt_ist = (ist_ff & ~i_clr) | i_set;
  always_ff @(posedge clk_i) begin
    ist_ff <= rst_i ? '0 : nxt_ist;
    irq_ff <= rst_i ? 1'b0 : |(nxt_ist & ien_ff);
  end

  // read mux; unmapped and write-only words read as zero
  wire [31:0] st_w = {26'h0, ahit_ff, vhit_ff, cfg_ff, tmo_ff, done_ff, run};
  wire [31:0] rd =
    (wb_adr_i == `AVSOM_OFF_CTRL)   ? {29'h0, dep_ff, 1'b0} :
    (wb_adr_i == `AVSOM_OFF_COL_R)  ? {20'h0, col_ff[0]} :
    (wb_adr_i == `AVSOM_OFF_COL_G)  ? {20'h0, col_ff[1]} :
    (wb_adr_i == `AVSOM_OFF_COL_B)  ? {20'h0, col_ff[2]} :
    (wb_adr_i == `AVSOM_OFF_TOL)    ? {20'h0, tol_ff} :
    (wb_adr_i == `AVSOM_OFF_ATHR)   ? {{(32-AW){1'b0}}, athr_ff} :
    (wb_adr_i == `AVSOM_OFF_MTIME)  ? mtime_ff :
    (wb_adr_i == `AVSOM_OFF_ONTIME) ? ontime_ff :
    (wb_adr_i == `AVSOM_OFF_STAT)   ? st_w :
    (wb_adr_i == `AVSOM_OFF_RES)    ? res_ff :
    (wb_adr_i == `AVSOM_OFF_ISTAT)  ? {29'h0, ist_ff} :
    (wb_adr_i == `AVSOM_OFF_IEN)    ? {29'h0, ien_ff} : 32'h0;

  // every access acks one cycle after the request appears
  always_ff @(posedge clk_i) begin
    ack_ff <= rst_i ? 1'b0 : req;
    dat_ff <= rst_i ? 32'h0 : (req ? rd : dat_ff);
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign irq_o    = irq_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start_ok;
    start && cfg_ok;
  endsequence

  sequence s_cleared;
    run && !vhit_ff && !ahit_ff && !tmo_ff && !done_ff;
  endsequence

  vid_window_a: assert property (vhit_ff && !$past(vhit_ff) && !$past(start)
      |-> $past(in_c) == 3'h7)
    else $error("video hit outside colour window");
  depth_mask_a: assert property (dep_ff == `AVSOM_DEP_8 |->
      (g_cmp[0].m[3:0] == 4'h0) && (g_cmp[2].m[3:0] == 4'h0))
    else $error("low colour bits not masked");
  bound_sat_a: assert property ((hi_c[0] >= col_ff[0])
      && (lo_c[0] <= col_ff[0]))
    else $error("colour bound wrapped");
  aud_trig_a: assert property (a_now && !start |-> a_mag > athr_ff
      ##1 (ahit_ff && ats_ff == $past(ts_ff)))
    else $error("audio trigger wrong");
  result_sign_a: assert property (ev_done && !start
      |=> done_ff && res_ff == vts_ff - ats_ff)
    else $error("offset result wrong");
  cfg_refuse_a: assert property (start && !cfg_ok
      |=> !run && cfg_ff ##1 ist_ff[`AVSOM_IRQ_CFG])
    else $error("bad config not refused");
  timeout_a: assert property (ev_tmo && !start
      |=> tmo_ff && !run && !done_ff)
    else $error("timeout not raised");
  window_a: assert property (run |-> win_ff < mtime_ff)
    else $error("run beyond window");
  latch_once_a: assert property (vhit_ff && !start |=> $stable(vts_ff))
    else $error("video timestamp moved");
  start_clear_a: assert property (s_start_ok |=> s_cleared)
    else $error("start did not clear");
endmodule
`default_nettype wire

// ---- test/avsom_far_model.sv ----
// far-side model: device under test replaying a two-colour pattern with sound
`timescale 1ns/1ps
`default_nettype none
module avsom_far_model (
  input  wire logic                     run_i,
  input  wire avsom_pkg::avsom_pix_type act_i,
  input  wire logic [7:0]               vd_i,
  input  wire logic [7:0]               ad_i,
  input  wire logic [15:0]              amp_i,
  output logic                          link_clk_o,
  output logic                          pix_de_o,
  output var avsom_pkg::avsom_pix_type  pix_o,
  output logic                          aud_valid_o,
  output logic [15:0]                   aud_o
);
  // idle colour sits outside every window the bench programs
  localparam avsom_pkg::avsom_pix_type MUTE = {12'h000, 12'hfff, 12'h000};
  logic [7:0] n;
  // link clock runs only within a frame; data moves on its falling edge
  initial begin
    link_clk_o = 1'b0;
    n = 8'h00;
    pix_de_o = 1'b0;
    pix_o = '0;
    aud_valid_o = 1'b0;
    aud_o = 16'h0000;
    #7;
    forever begin
      if (run_i) begin
        link_clk_o = 1'b1;
        #80;
        link_clk_o = 1'b0;
        pix_de_o = 1'b1;
        aud_valid_o = 1'b1;
        pix_o = (n >= vd_i) ? act_i : MUTE;
        aud_o = (n >= ad_i) ? amp_i : 16'h0000; // gated sound, silence is zero
        n = n + 8'h01;
        #80;
      end else begin
        // released lines keep toggling so stale values never look valid
        n = 8'h00;
        pix_de_o = 1'b0;
        aud_valid_o = 1'b0;
        pix_o = ~pix_o;
        aud_o = ~aud_o;
        #160;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the av offset meter over its wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "avsom_regs.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %0t value mismatch", $time); end end
module tb_top;
  localparam int LK = 8; // clk_i cycles per link cycle
  logic        clk_i, rst_i, cyc, stb, we, run, irq_o, wb_ack_o;
  logic        lclk, de, av;
  logic [7:0]  adr, vd, ad;
  logic [31:0] wdat, wb_dat_o, st;
  logic [15:0] amp, aud;
  avsom_pkg::avsom_pix_type act, pix;
  int err_count, samples_checked, cycles;
  // ===========================================================
  // instances
  avsom_meter u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .link_clk_i(lclk), .pix_de_i(de), .pix_i(pix),
    .aud_valid_i(av), .aud_i(aud));
  avsom_far_model u_far (.run_i(run), .act_i(act), .vd_i(vd), .ad_i(ad),
    .amp_i(amp), .link_clk_o(lclk), .pix_de_o(de), .pix_o(pix),
    .aud_valid_o(av), .aud_o(aud));
  // ===========================================================
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      wrap_up();
    end
  end
  // ===========================================================
  // tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  function automatic avsom_pkg::avsom_pix_type px(input logic [11:0] r,
                                                  g, b);
    return {r, g, b};
  endfunction
  // irq_o is registered, so let two edges pass before looking
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, e)
  endtask
  // program window, start, let the far side play, then judge outcome
  task automatic meas(input logic [1:0] dp, input avsom_pkg::avsom_pix_type rf,
                      a, input logic [11:0] tl, input logic [15:0] am,
                      input logic [7:0] v, d, input logic ok);
    logic [31:0] q;
    int k;
    wr(`AVSOM_OFF_COL_R, {20'h0, rf.r});
    wr(`AVSOM_OFF_COL_G, {20'h0, rf.g});
    wr(`AVSOM_OFF_COL_B, {20'h0, rf.b});
    wr(`AVSOM_OFF_TOL, {20'h0, tl});
    act <= a;
    amp <= am;
    vd <= v;
    ad <= d;
    wr(`AVSOM_OFF_CTRL, {29'h0, dp, 1'b1});
    @(posedge clk_i) run <= 1'b1;
    k = 0;
    do begin
      wb(1'b0, `AVSOM_OFF_STAT, 32'h0, q);
      k++;
    end while (q[0] !== 1'b0 && k < 100);
    run <= 1'b0;
    `CHK(q[2:1], {~ok, ok})
    if (ok) begin
      `CHK(q[5:4], 2'h3)
      wb(1'b0, `AVSOM_OFF_RES, 32'h0, q);
      `CHK(q, 32'(LK * (int'(v) - int'(d))))
    end
    $display("test measurement finished");
  endtask
  // ===========================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, run} = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    {act, amp, vd, ad} = '0;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place reads zero
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, (i == 4) ? 8'h3c : 8'h20 + 8'(i * 4), 32'h0, st);
      `CHK(st, 32'h0)
    end
    `CHK(irq_o, 1'b0)
    wb(1'b0, `AVSOM_OFF_IEN, 32'h0, st);
    `CHK(st, 32'h0)
    $display("test reset values finished");
    // window not longer than on-time is refused
    wr(`AVSOM_OFF_MTIME, 32'd100);
    wr(`AVSOM_OFF_ONTIME, 32'd100);
    wr(`AVSOM_OFF_IEN, 32'h4);
    wr(`AVSOM_OFF_CTRL, 32'h1);
    wb(1'b0, `AVSOM_OFF_STAT, 32'h0, st);
    `CHK({st[3], st[0]}, 2'h2)
    irq_is(1'b1);
    wr(`AVSOM_OFF_ICLR, 32'h4);
    irq_is(1'b0);
    $display("test refused start finished");
    wr(`AVSOM_OFF_MTIME, 32'd200);
    wr(`AVSOM_OFF_ATHR, 32'd10);
    meas(2'h0, px(12'hfff, 0, 0), px(12'hfff, 0, 0), 12'h064, 16'd11, 2, 5, 1);
    meas(2'h0, px(12'hfff, 0, 0), px(12'hfff, 0, 0), 12'h064, 16'd11, 5, 2, 1);
    meas(2'h0, px(12'hfff, 0, 0), px(12'hf9b, 0, 0), 12'h064, 16'd11, 3, 3, 1);
    meas(2'h0, px(12'hfff, 0, 0), px(12'hf9a, 0, 0), 12'h064, 16'd11, 3, 3, 0);
    meas(2'h0, px(12'hfff, 0, 0), px(12'hfff, 12'h065, 0), 12'h064, 16'd11, 1, 1, 0);
    meas(2'h0, px(12'hfff, 0, 0), px(12'hfff, 0, 0), 12'h064, 16'd10, 1, 1, 0);
    meas(2'h0, px(12'h100, 12'h100, 12'h100), px(12'h10f, 12'h10f, 12'h10f), 0, 16'd11, 1, 4, 0);
    meas(2'h2, px(12'h100, 12'h100, 12'h100), px(12'h10f, 12'h10f, 12'h10f), 0, 16'd11, 1, 4, 1);
    meas(2'h1, px(12'h100, 12'h100, 12'h100), px(12'h103, 12'h103, 12'h103), 0, 16'd11, 4, 1, 1);
    meas(2'h1, px(12'h100, 12'h100, 12'h100), px(12'h104, 12'h104, 12'h104), 0, 16'd11, 4, 1, 0);
    meas(2'h0, px(12'hfff, 0, 0), px(12'hfff, 0, 0), 12'h064, 16'd11, 0, 3, 1);
    // done flag raises the line only while enabled, and clears
    wr(`AVSOM_OFF_IEN, 32'h1);
    irq_is(1'b1);
    wr(`AVSOM_OFF_IEN, 32'h0);
    irq_is(1'b0);
    wr(`AVSOM_OFF_ICLR, 32'h7);
    wr(`AVSOM_OFF_IEN, 32'h1);
    irq_is(1'b0);
    $display("test interrupt finished");
    wrap_up();
  end
endmodule
`default_nettype wire
